// *** rtl/switch_output_conditioning_regs.svh ***
// register map, field positions, reset values and timing constants of the switch conditioner
`ifndef SWITCH_OUTPUT_CONDITIONING_REGS_SVH
`define SWITCH_OUTPUT_CONDITIONING_REGS_SVH

// widths
`define VAL_W        24
`define DLY_W        12
`define SPAN_W       16
`define SPAN_FRAC    14
`define NUM_CH       4
`define DIV_STEPS    6'd38

// register byte offsets
`define OFS_CTRL     12'h000
`define OFS_STATUS   12'h004
`define OFS_SHIFT    12'h008
`define OFS_SPAN     12'h00c
`define OFS_REFTHK   12'h010
`define OFS_CALVAL   12'h014
`define OFS_CH_BASE  12'h020
`define CH_STRIDE_B  4
`define OFS_UPPER    2'd0
`define OFS_LOWER    2'd1
`define OFS_HYST     2'd2
`define OFS_DELAY    2'd3

// control register fields
`define CTRL_THICK   0
`define CTRL_POLLOW  1
`define CTRL_FUNC_LO 2
`define CTRL_FUNC_HI 3
`define CTRL_TEACH   8

// status register fields
`define STAT_OUT_LO  0
`define STAT_OUT_HI  3
`define STAT_LASER   4
`define STAT_BUSY    5
`define STAT_MFACT   6

// channel delay register fields
`define DLY_ON_LO    0
`define DLY_ON_HI    11
`define DLY_OFF_LO   16
`define DLY_OFF_HI   27
`define DLY_ONESHOT  31

// reset values
`define RST_SPAN     16'h4000
`define RST_SHIFT    24'h000000
`define RST_UPPER    24'h0003e8
`define RST_LOWER    24'hfffc18
`define RST_HYST     24'h00000a
`define RST_DLY      12'h000
`define DLY_MAX      12'hfa0

// timing
`define CLK_PERIOD_NS 40
`define MS_NS         1000000

`endif

// *** rtl/switch_output_conditioning_pkg.sv ***
// types shared by the switch output conditioning block
package switch_output_conditioning_pkg;
	`include "switch_output_conditioning_regs.svh"

	// multifunction input function selection
	typedef enum logic [1:0] {
		MF_NONE      = 2'b00,
		MF_LASER_OFF = 2'b01
	} mf_func_t;

	// per channel output sequencer
	typedef enum logic [2:0] {
		CH_IDLE     = 3'b000,
		CH_ON_WAIT  = 3'b001,
		CH_ON       = 3'b010,
		CH_OFF_WAIT = 3'b011,
		CH_PULSE    = 3'b100,
		CH_SPENT    = 3'b101
	} ch_state_t;

	// one switching channel: settings and run state
	typedef struct packed {
		logic signed [`VAL_W-1:0] upper;
		logic signed [`VAL_W-1:0] lower;
		logic        [`VAL_W-1:0] hyst;
		logic        [`DLY_W-1:0] on_dly;
		logic        [`DLY_W-1:0] off_dly;
		logic                     one_shot;
		ch_state_t                st;
		logic        [`DLY_W-1:0] cnt;
		logic                     cond;
		logic                     out;
	} chan_t;

	// latched ahb address phase
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
	} ahb_phase_t;

	// whole block state
	typedef struct packed {
		ahb_phase_t                    ap;
		logic                   [31:0] rdata;
		logic                          hready;
		logic                          thick;
		logic                          pol_low;
		mf_func_t                      func;
		logic signed [`VAL_W-1:0]      shift;
		logic        [`SPAN_W-1:0]     span;
		logic        [`VAL_W-1:0]      ref_thk;
		logic signed [`VAL_W-1:0]      raw;
		logic signed [`VAL_W-1:0]      cal;
		logic                          cal_valid;
		logic                          raw_new;
		logic                   [1:0]  mf_sync;
		logic                          mf_act;
		logic                          laser_off;
		logic                   [14:0] ms_cnt;
		logic                          ms_tick;
		logic                          busy;
		logic                   [5:0]  step;
		logic                   [24:0] rem;
		logic                   [37:0] quo;
		logic                   [23:0] den;
		chan_t [`NUM_CH-1:0]           ch;
	} state_t;
endpackage

// *** rtl/switch_output_conditioning.sv ***
// switch output conditioning: calibration, hysteresis, delays, one-shot, multifunction input
//
// Summary of operation
// - hysteresis band stops toggling near thresholds
// - switch-on waits for configured on delay
// - on delay 0..4000 ms, reset zero
// - output held for off delay after drop
// - off delay 0..4000 ms, reset zero
// - off delay swallows short condition dropouts
// - signed shift added to each measurement outside thickness mode
// - span factor scales each measurement
// - thickness mode uses span, no shift
// - thickness teach computes span from reference
// - span and shift writable after teach
// - one-shot pulses once while condition persists
// - one-shot pulse length is off delay
// - one-shot still waits the on delay
// - input polarity selects active sense
// - polarity resets to high, normally open
// - function none ignores the input
// - laser off while input active
// - input function resets to none
// - four channels reported as data bits
// - upper and lower limits set thresholds
`timescale 1ns/1ps

module switch_output_conditioning
	import switch_output_conditioning_pkg::*;
#(
	// clock cycles per millisecond
	parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire  logic                     hclk,
	input  wire  logic                     hresetn,
	// ahb-lite slave
	input  wire  logic                     hsel,
	input  wire  logic [31:0]              haddr,
	input  wire  logic [1:0]               htrans,
	input  wire  logic                     hwrite,
	input  wire  logic [2:0]               hsize,
	input  wire  logic [31:0]              hwdata,
	input  wire  logic                     hready,
	output logic       [31:0]              hrdata,
	output logic                           hreadyout,
	output logic                           hresp,
	// measured value stream from the sensor head
	input  wire  logic                     meas_valid,
	input  wire  logic signed [`VAL_W-1:0] meas_value,
	// calibrated value stream
	output logic                           cal_valid,
	output logic signed [`VAL_W-1:0]       cal_value,
	// switching signals, one per channel
	output logic [`NUM_CH-1:0]             switch_out,
	// multifunction input pin and laser control
	input  wire  logic                     multifunction_input,
	output logic                           laser_off
);

	state_t                   s_r;        // registered state
	state_t                   s_nxt;      // next state
	logic signed [40:0]       prod;       // raw times span
	logic signed [`VAL_W-1:0] scaled;     // span applied
	logic                     ap_take;    // address phase accepted
	logic [11:0]              wa;         // data phase address
	logic [3:0]               ch_sel;     // decoded channel of an access
	logic [1:0]               ch_reg;     // register within a channel
	logic                     ch_hit;     // access falls in channel space
	logic signed [`VAL_W:0]   on_lo;      // lower limit with sign room
	logic signed [`VAL_W:0]   on_hi;      // upper limit with sign room
	logic signed [`VAL_W:0]   v;          // calibrated value with sign room
	logic                     go;         // delay count finished
	logic [`DLY_W-1:0]        clamp_on;   // written on delay, clamped
	logic [`DLY_W-1:0]        clamp_off;  // written off delay, clamped

	// span multiply, fixed point with SPAN_FRAC fraction bits
	// both operands widened first so the product is formed at full width
	assign prod   = 41'(s_r.raw) * 41'($signed({1'b0, s_r.span}));
	assign scaled = prod[`SPAN_FRAC +: `VAL_W];

	// next state
	always_comb begin
		s_nxt = s_r;
		ap_take = hsel && hready && htrans[1];
		wa = s_r.ap.addr;
		ch_hit = (wa >= `OFS_CH_BASE) && (wa < `OFS_CH_BASE + 12'h040);
		ch_sel = 4'((wa - `OFS_CH_BASE) >> 4);
		ch_reg = wa[3:2];
		clamp_on = (hwdata[`DLY_ON_HI:`DLY_ON_LO] > `DLY_MAX) ? `DLY_MAX
			: hwdata[`DLY_ON_HI:`DLY_ON_LO];
		clamp_off = (hwdata[`DLY_OFF_HI:`DLY_OFF_LO] > `DLY_MAX) ? `DLY_MAX
			: hwdata[`DLY_OFF_HI:`DLY_OFF_LO];
		on_lo = '0;
		on_hi = '0;
		v = '0;
		go = 1'b0;

		// zero wait state slave, always okay
		s_nxt.hready = 1'b1;
		s_nxt.ap.wr = ap_take && hwrite;
		s_nxt.ap.rd = ap_take && !hwrite;
		s_nxt.ap.addr = {haddr[11:2], 2'b00};

		// read data prepared at the end of the address phase
		s_nxt.rdata = '0;
		if (ap_take && !hwrite) begin
			case ({haddr[11:2], 2'b00})
				`OFS_CTRL: begin
					s_nxt.rdata[`CTRL_THICK] = s_r.thick;
					s_nxt.rdata[`CTRL_POLLOW] = s_r.pol_low;
					s_nxt.rdata[`CTRL_FUNC_HI:`CTRL_FUNC_LO] = s_r.func;
				end
				`OFS_STATUS: begin
					for (int i = 0; i < `NUM_CH; i++) begin
						s_nxt.rdata[`STAT_OUT_LO + i] = s_r.ch[i].out;
					end
					s_nxt.rdata[`STAT_LASER] = s_r.laser_off;
					s_nxt.rdata[`STAT_BUSY] = s_r.busy;
					s_nxt.rdata[`STAT_MFACT] = s_r.mf_act;
				end
				`OFS_SHIFT:  s_nxt.rdata = 32'($signed(s_r.shift));
				`OFS_SPAN:   s_nxt.rdata[`SPAN_W-1:0] = s_r.span;
				`OFS_REFTHK: s_nxt.rdata[`VAL_W-1:0] = s_r.ref_thk;
				`OFS_CALVAL: s_nxt.rdata = 32'($signed(s_r.cal));
				default: begin
					// channel registers, else unmapped reads zero
					for (int i = 0; i < `NUM_CH; i++) begin
						if (haddr[11:4] == 8'((`OFS_CH_BASE >> 4) + i)) begin
							case (haddr[3:2])
								`OFS_UPPER: s_nxt.rdata = 32'($signed(s_r.ch[i].upper));
								`OFS_LOWER: s_nxt.rdata = 32'($signed(s_r.ch[i].lower));
								`OFS_HYST:  s_nxt.rdata[`VAL_W-1:0] = s_r.ch[i].hyst;
								default: begin
									s_nxt.rdata[`DLY_ON_HI:`DLY_ON_LO] = s_r.ch[i].on_dly;
									s_nxt.rdata[`DLY_OFF_HI:`DLY_OFF_LO] = s_r.ch[i].off_dly;
									s_nxt.rdata[`DLY_ONESHOT] = s_r.ch[i].one_shot;
								end
							endcase
						end
					end
				end
			endcase
		end

		// writes land in the data phase
		if (s_r.ap.wr) begin
			case (wa)
				`OFS_CTRL: begin
					s_nxt.thick = hwdata[`CTRL_THICK];
					s_nxt.pol_low = hwdata[`CTRL_POLLOW];
					s_nxt.func = mf_func_t'(hwdata[`CTRL_FUNC_HI:`CTRL_FUNC_LO]);
					// teach start, ignored while a teach runs or the value is zero
					if (hwdata[`CTRL_TEACH] && !s_r.busy && s_r.raw != '0) begin
						s_nxt.busy = 1'b1;
						s_nxt.step = '0;
						s_nxt.rem = '0;
						s_nxt.quo = {s_r.ref_thk, {`SPAN_FRAC{1'b0}}};
						s_nxt.den = s_r.raw[`VAL_W-1] ? 24'(-s_r.raw) : 24'(s_r.raw);
					end
				end
				`OFS_SHIFT:  s_nxt.shift = hwdata[`VAL_W-1:0];
				`OFS_SPAN:   s_nxt.span = hwdata[`SPAN_W-1:0];
				`OFS_REFTHK: s_nxt.ref_thk = hwdata[`VAL_W-1:0];
				default: begin
					if (ch_hit) begin
						case (ch_reg)
							`OFS_UPPER: s_nxt.ch[ch_sel].upper = hwdata[`VAL_W-1:0];
							`OFS_LOWER: s_nxt.ch[ch_sel].lower = hwdata[`VAL_W-1:0];
							`OFS_HYST:  s_nxt.ch[ch_sel].hyst = hwdata[`VAL_W-1:0];
							default: begin
								s_nxt.ch[ch_sel].on_dly = clamp_on;
								s_nxt.ch[ch_sel].off_dly = clamp_off;
								s_nxt.ch[ch_sel].one_shot = hwdata[`DLY_ONESHOT];
							end
						endcase
					end
				end
			endcase
		end

		// thickness teach: span = reference / current value, restoring division
		if (s_r.busy) begin
			s_nxt.rem = {s_r.rem[23:0], s_r.quo[37]};
			s_nxt.quo = {s_r.quo[36:0], 1'b0};
			if ({s_r.rem[23:0], s_r.quo[37]} >= {1'b0, s_r.den}) begin
				s_nxt.rem = {s_r.rem[23:0], s_r.quo[37]} - {1'b0, s_r.den};
				s_nxt.quo[0] = 1'b1;
			end
			s_nxt.step = s_r.step + 6'd1;
			if (s_r.step == `DIV_STEPS - 6'd1) begin
				s_nxt.busy = 1'b0;
				// saturate to the span range, then apply to later values
				s_nxt.span = (s_nxt.quo[37:`SPAN_W] != '0) ? '1 : s_nxt.quo[`SPAN_W-1:0];
			end
		end

		// calibration of each incoming value
		if (meas_valid) begin
			s_nxt.raw = meas_value;
		end
		// the pulse follows two edges after meas_valid, together with the value it marks
		s_nxt.raw_new = meas_valid;
		s_nxt.cal_valid = s_r.raw_new;
		// thickness mode leaves the shift out
		s_nxt.cal = s_r.thick ? scaled : `VAL_W'(scaled + s_r.shift);

		// millisecond enable
		s_nxt.ms_tick = 1'b0;
		s_nxt.ms_cnt = s_r.ms_cnt + 15'd1;
		if (s_r.ms_cnt == 15'(MS_CYCLES - 1)) begin
			s_nxt.ms_cnt = '0;
			s_nxt.ms_tick = 1'b1;
		end

		// multifunction input: synchroniser, polarity, function
		s_nxt.mf_sync = {s_r.mf_sync[0], multifunction_input};
		s_nxt.mf_act = s_r.mf_sync[1] ^ s_r.pol_low;
		s_nxt.laser_off = (s_r.func == MF_LASER_OFF) && s_r.mf_act;

		// channels, each with its own settings
		v = {s_r.cal[`VAL_W-1], s_r.cal};
		for (int i = 0; i < `NUM_CH; i++) begin
			on_lo = {s_r.ch[i].lower[`VAL_W-1], s_r.ch[i].lower};
			on_hi = {s_r.ch[i].upper[`VAL_W-1], s_r.ch[i].upper};
			// window condition, released only beyond the band
			if (!s_r.ch[i].cond) begin
				s_nxt.ch[i].cond = (v >= on_lo) && (v <= on_hi);
			end else begin
				s_nxt.ch[i].cond = (v >= on_lo - $signed({1'b0, s_r.ch[i].hyst}))
					&& (v <= on_hi + $signed({1'b0, s_r.ch[i].hyst}));
			end
			case (s_r.ch[i].st)
				CH_IDLE: begin
					s_nxt.ch[i].cnt = '0;
					if (s_r.ch[i].cond) begin
						s_nxt.ch[i].st = CH_ON_WAIT;
						if (s_r.ch[i].on_dly == '0) begin
							s_nxt.ch[i].st = s_r.ch[i].one_shot ? CH_PULSE : CH_ON;
							s_nxt.ch[i].out = 1'b1;
						end
					end
				end
				CH_ON_WAIT: begin
					go = s_r.ms_tick && (s_r.ch[i].cnt + 12'd1 >= s_r.ch[i].on_dly);
					if (!s_r.ch[i].cond) begin
						s_nxt.ch[i].st = CH_IDLE;
						s_nxt.ch[i].cnt = '0;
					end else if (go) begin
						s_nxt.ch[i].st = s_r.ch[i].one_shot ? CH_PULSE : CH_ON;
						s_nxt.ch[i].cnt = '0;
						s_nxt.ch[i].out = 1'b1;
					end else if (s_r.ms_tick) begin
						s_nxt.ch[i].cnt = s_r.ch[i].cnt + 12'd1;
					end
				end
				CH_ON: begin
					s_nxt.ch[i].cnt = '0;
					if (!s_r.ch[i].cond) begin
						if (s_r.ch[i].off_dly == '0) begin
							s_nxt.ch[i].st = CH_IDLE;
							s_nxt.ch[i].out = 1'b0;
						end else begin
							s_nxt.ch[i].st = CH_OFF_WAIT;
						end
					end
				end
				CH_OFF_WAIT: begin
					go = s_r.ms_tick && (s_r.ch[i].cnt + 12'd1 >= s_r.ch[i].off_dly);
					if (s_r.ch[i].cond) begin
						s_nxt.ch[i].st = CH_ON;
					end else if (go) begin
						s_nxt.ch[i].st = CH_IDLE;
						s_nxt.ch[i].out = 1'b0;
					end else if (s_r.ms_tick) begin
						s_nxt.ch[i].cnt = s_r.ch[i].cnt + 12'd1;
					end
				end
				CH_PULSE: begin
					// pulse lasts the off delay, at least one cycle
					go = (s_r.ch[i].off_dly == '0)
						|| (s_r.ms_tick && (s_r.ch[i].cnt + 12'd1 >= s_r.ch[i].off_dly));
					if (go) begin
						s_nxt.ch[i].st = CH_SPENT;
						s_nxt.ch[i].out = 1'b0;
					end else if (s_r.ms_tick) begin
						s_nxt.ch[i].cnt = s_r.ch[i].cnt + 12'd1;
					end
				end
				CH_SPENT: begin
					// rearm only once the condition has gone
					if (!s_r.ch[i].cond) begin
						s_nxt.ch[i].st = CH_IDLE;
					end
				end
				default: begin
					s_nxt.ch[i].st = CH_IDLE;
					s_nxt.ch[i].out = 1'b0;
				end
			endcase
			// leaving one-shot mode after the pulse, while spent, drops back to idle
			if (!s_r.ch[i].one_shot && s_r.ch[i].st == CH_SPENT) begin
				s_nxt.ch[i].st = CH_IDLE;
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.hready <= 1'b1;
			s_r.pol_low <= 1'b0;
			s_r.func <= MF_NONE;
			s_r.span <= `RST_SPAN;
			s_r.shift <= `RST_SHIFT;
			for (int i = 0; i < `NUM_CH; i++) begin
				s_r.ch[i].upper <= `RST_UPPER;
				s_r.ch[i].lower <= `RST_LOWER;
				s_r.ch[i].hyst <= `RST_HYST;
				s_r.ch[i].on_dly <= `RST_DLY;
				s_r.ch[i].off_dly <= `RST_DLY;
				s_r.ch[i].st <= CH_IDLE;
			end
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign hrdata = s_r.rdata;
	assign hreadyout = s_r.hready;
	assign hresp = 1'b0 & s_r.hready;
	assign cal_valid = s_r.cal_valid;
	assign cal_value = s_r.cal;
	assign laser_off = s_r.laser_off;
	always_comb begin
		for (int i = 0; i < `NUM_CH; i++) begin
			switch_out[i] = s_r.ch[i].out;
		end
	end

endmodule

// *** verification/sensor_head_model.sv ***
// sensor head model: repeats a measured value as a pulse stream every four cycles
`timescale 1ns/1ps

module sensor_head_model
	import switch_output_conditioning_pkg::*;
(
	// clock and reset
	input  wire  logic                     hclk,
	input  wire  logic                     hresetn,
	// value to report
	input  wire  logic signed [`VAL_W-1:0] target,
	// measured value stream
	output logic                           meas_valid,
	output logic signed [`VAL_W-1:0]       meas_value
);
	logic [1:0] phase_r; // cycle within the report period

	// one pulse per period; between pulses the value line shows a changing pattern
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r    <= 2'h0;
			meas_valid <= 1'b0;
			meas_value <= '0;
		end else begin
			phase_r    <= phase_r + 2'h1;
			meas_valid <= (phase_r == 2'h3);
			meas_value <= (phase_r == 2'h3) ? target : ~meas_value;
		end
	end
endmodule

// *** verification/switch_output_conditioning_asserts.sv ***
// checker for the bus, measurement stream and laser control ports
`timescale 1ns/1ps

module switch_output_conditioning_asserts
	import switch_output_conditioning_pkg::*;
#(
	parameter int MS_CYCLES = 10
) (
	// clock and reset
	input wire logic                     hclk,
	input wire logic                     hresetn,
	// bus
	input wire logic                     hsel,
	input wire logic [31:0]              haddr,
	input wire logic [1:0]               htrans,
	input wire logic                     hwrite,
	input wire logic                     hready,
	input wire logic [31:0]              hrdata,
	input wire logic                     hreadyout,
	input wire logic                     hresp,
	// streams and pins
	input wire logic                     meas_valid,
	input wire logic                     cal_valid,
	input wire logic [`NUM_CH-1:0]       switch_out,
	input wire logic                     multifunction_input,
	input wire logic                     laser_off
);
	logic       rd_q;     // read taken last edge
	logic [11:0] addr_q;  // its address
	logic [3:0] pin_age;  // cycles since the pin moved
	logic [3:0] wr_age;   // cycles since a write was taken
	logic       pin_q;    // pin one edge ago

	// track bus phases and recent causes of a laser change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q    <= 1'b0;
			addr_q  <= 12'h000;
			pin_age <= 4'hf;
			wr_age  <= 4'hf;
			pin_q   <= 1'b0;
		end else begin
			rd_q    <= hsel & hready & htrans[1] & ~hwrite;
			addr_q  <= haddr[11:0];
			pin_q   <= multifunction_input;
			pin_age <= (pin_q != multifunction_input) ? 4'h0 : pin_age + {3'h0, pin_age != 4'hf};
			wr_age  <= (hsel & hready & htrans[1] & hwrite) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state seen");
	a_cal_latency: assert property (meas_valid |-> ##2 cal_valid) else $error("cal pulse late");
	a_cal_origin: assert property (cal_valid |-> $past(meas_valid, 2)) else $error("stray cal pulse");
	a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata outside read");
	a_unmapped_zero: assert property (rd_q && addr_q == 12'hffc |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_reset_outs: assert property ($rose(hresetn) |-> switch_out == 4'h0 && !laser_off && !cal_valid)
		else $error("outputs not cleared by reset");
	a_laser_cause: assert property ($changed(laser_off) |-> pin_age < 4'h8 || wr_age < 4'h8)
		else $error("laser changed without cause");
endmodule

bind switch_output_conditioning switch_output_conditioning_asserts #(.MS_CYCLES(MS_CYCLES)) chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.meas_valid(meas_valid), .cal_valid(cal_valid), .switch_out(switch_out),
	.multifunction_input(multifunction_input), .laser_off(laser_off));

// *** verification/switch_output_conditioning_tb.sv ***
// testbench: register access, calibration, channel timing and input function
`timescale 1ns/1ps

module switch_output_conditioning_tb
	import switch_output_conditioning_pkg::*;
;
	logic                     hclk = 1'b0;
	logic                     hresetn = 1'b0;
	logic                     hsel = 1'b1;
	logic [31:0]              haddr = 32'h0;
	logic [1:0]               htrans = 2'h0;
	logic                     hwrite = 1'b0;
	logic [31:0]              hwdata = 32'h0;
	logic [31:0]              hrdata;
	logic                     hreadyout;
	logic                     hresp;
	logic                     meas_valid;
	logic signed [`VAL_W-1:0] meas_value;
	logic signed [`VAL_W-1:0] target = 24'sd100;
	logic                     cal_valid;
	logic signed [`VAL_W-1:0] cal_value;
	logic [`NUM_CH-1:0]       switch_out;
	logic                     mf_pin = 1'b0;
	logic                     laser_off;
	int                       mismatches = 0;
	int                       compares = 0;
	logic [31:0]              rv;

	switch_output_conditioning #(.MS_CYCLES(10)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid), .meas_value(meas_value),
		.cal_valid(cal_valid), .cal_value(cal_value), .switch_out(switch_out),
		.multifunction_input(mf_pin), .laser_off(laser_off));

	sensor_head_model head (.hclk(hclk), .hresetn(hresetn), .target(target),
		.meas_valid(meas_valid), .meas_value(meas_value));

	// clock at 25 MHz
	initial begin
		forever #20 hclk = ~hclk;
	end

	// verdict and end of run
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single transfer: address phase held until ready, then data phase
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rv & m);
	endtask

	// new value from the head, then let it reach the outputs
	task automatic put(input logic signed [`VAL_W-1:0] v);
		target <= v;
		repeat (14) @(posedge hclk);
	endtask

	// wait a bounded time for channel 0 to reach a level
	task automatic wait0(input logic v, input int n);
		for (int i = 0; i < n && switch_out[0] !== v; i++) @(posedge hclk);
		chk("switch_out0", {31'h0, v}, {31'h0, switch_out[0]});
	endtask

	// channel 0 must hold a level for n cycles
	task automatic hold0(input logic v, input int n);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			if (switch_out[0] !== v) ok = 1'b0;
		end
		chk("switch_out0_held", 32'h1, {31'h0, ok});
	endtask

	// watchdog
	initial begin
		#3000000;
		mismatches++;
		end_of_test();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ctrl", 12'h000, 32'h0, 32'hffffffff);
		rd_chk("span", 12'h00c, 32'h4000, 32'hffff);
		rd_chk("shift", 12'h008, 32'h0, 32'hffffff);
		rd_chk("upper", 12'h020, 32'h3e8, 32'hffffff);
		rd_chk("lower", 12'h024, 32'hfffc18, 32'hffffff);
		rd_chk("hyst", 12'h028, 32'ha, 32'hffffff);
		rd_chk("delay", 12'h02c, 32'h0, 32'hffffffff);
		rd_chk("unmapped", 12'hffc, 32'h0, 32'hffffffff);
		wr(12'h02c, 32'h0fff0fff);
		rd_chk("delay_clamp", 12'h02c, 32'h0fa00fa0, 32'hffffffff);
		wr(12'h02c, 32'h0);
		put(24'sd100);
		chk("cal_plain", 32'd100, {8'h0, cal_value});
		wr(12'h008, 32'd5);
		put(24'sd100);
		chk("cal_shift", 32'd105, {8'h0, cal_value});
		wr(12'h00c, 32'h8000);
		put(24'sd100);
		chk("cal_span", 32'd205, {8'h0, cal_value});
		wr(12'h000, 32'h1);
		put(24'sd100);
		chk("cal_thick", 32'd200, {8'h0, cal_value});
		wr(12'h010, 32'd100 + 32'd200);
		wr(12'h000, 32'h101);
		rv = 32'h20;
		for (int i = 0; i < 20 && rv[5] !== 1'b0; i++) xfer(1'b0, 12'h004, 32'h0);
		rd_chk("span_teach", 12'h00c, 32'hc000, 32'hffff);
		put(24'sd100);
		chk("cal_teach", 32'd300, {8'h0, cal_value});
		wr(12'h00c, 32'h4000);
		rd_chk("span_manual", 12'h00c, 32'h4000, 32'hffff);
		wr(12'h000, 32'h0);
		wr(12'h008, 32'h0);
		wr(12'h030, 32'd200);
		put(24'sd500);
		chk("switch_out", 32'hd, {28'h0, switch_out});
		put(24'sd1005);
		chk("switch_in_band", 32'hd, {28'h0, switch_out});
		put(24'sd1011);
		chk("switch_past_band", 32'h0, {28'h0, switch_out});
		put(24'sd1005);
		chk("switch_stay_off", 32'h0, {28'h0, switch_out});
		wr(12'h02c, 32'h4);
		put(24'sd500);
		chk("on_delay_wait", 32'h0, {31'h0, switch_out[0]});
		wait0(1'b1, 60);
		put(24'sd2000);
		target <= 24'sd500;
		repeat (12) @(posedge hclk);
		put(24'sd2000);
		hold0(1'b0, 60);
		wr(12'h02c, 32'h00040000);
		put(24'sd500);
		wait0(1'b1, 20);
		put(24'sd2000);
		chk("off_delay_hold", 32'h1, {31'h0, switch_out[0]});
		wait0(1'b0, 60);
		put(24'sd500);
		target <= 24'sd2000;
		repeat (10) @(posedge hclk);
		target <= 24'sd500;
		hold0(1'b1, 80);
		wr(12'h02c, 32'h80020003);
		put(24'sd2000);
		wait0(1'b0, 60);
		put(24'sd500);
		chk("shot_on_delay", 32'h0, {31'h0, switch_out[0]});
		wait0(1'b1, 60);
		hold0(1'b1, 9);
		wait0(1'b0, 30);
		hold0(1'b0, 60);
		mf_pin <= 1'b1;
		repeat (10) @(posedge hclk);
		chk("laser_none", 32'h0, {31'h0, laser_off});
		wr(12'h000, 32'h4);
		repeat (10) @(posedge hclk);
		chk("laser_active", 32'h1, {31'h0, laser_off});
		wr(12'h000, 32'h6);
		repeat (10) @(posedge hclk);
		chk("laser_pol_low", 32'h0, {31'h0, laser_off});
		mf_pin <= 1'b0;
		repeat (10) @(posedge hclk);
		chk("laser_pol_low_idle", 32'h1, {31'h0, laser_off});
		end_of_test();
	end
endmodule
